// ### pkg/ucc_consts.svh
// Register map, field positions and reset values of the cache controller.
// Assumes inclusion by bare name; definitions only.
`ifndef UCC_CONSTS_SVH
`define UCC_CONSTS_SVH

// Register byte offsets
`define UCC_OFS_IDENTITY   12'h000
`define UCC_OFS_GEOMETRY   12'h004
`define UCC_OFS_CONTROL    12'h100
`define UCC_OFS_INVALIDATE 12'h700

// Control register fields
`define UCC_EN_BIT         0
`define UCC_RDY_BIT        16
`define UCC_EN_RST         1'b0

// Identity register fields
`define UCC_ID_LSB         10
`define UCC_PART_LSB       6
`define UCC_REL_LSB        0

// Geometry register fields
`define UCC_MEM_LSB        16
`define UCC_KB_BYTES       1024

// Shared bank address range
`define UCC_BANK_LO        32'h2001_C000
`define UCC_BANK_HI        32'h2001_FFFF

`define UCC_ZERO32         32'h0000_0000

`endif

// ### pkg/ucc_pkg.sv
// Types shared by the cache controller design.
// Assumes ucc_consts.svh for numeric constants.
package ucc_pkg;

  // Fetch sequencer states
  typedef enum logic {
    UCC_IDLE,
    UCC_MISS
  } ucc_state_t;

  // Line fill buffer: one word held with its word address
  typedef struct packed {
    logic        valid;
    logic [29:0] waddr;
    logic [31:0] data;
  } ucc_line_t;

endpackage : ucc_pkg

// ### hw/ucc_top.sv
// Unified code cache controller, one instance: 2-way set-associative
// storage, line fill buffer, register port, flash port, shared bank gate.
// Assumes fetch, flash, flush and zeroize signals come from logic on clk_in.
//
// Behaviour
// [RULE1] Enabled instance has line buffer, tag store and 16KB two-way storage.
// [RULE2] Enabled secondary instance blocks ordinary access to the shared bank range.
// [RULE3] Disabled secondary instance reopens the bank, honouring RISC-core exclusivity.
// [RULE4] Software enables: write 0, write 1, poll ready, then zeroize.
// [RULE5] Software should zeroize the shared bank before enabling secondary.
// [RULE6] Enable bit 0, reset 0; writing 1 turns caching on.
// [RULE7] Writing enable 0 disables and invalidates; fill buffer serves reads.
// [RULE8] Any write to the invalidate register invalidates the whole cache.
// [RULE9] Ready bit 16 reads 0 during invalidation, returns 1 when done.
// [RULE10] While not ready, storage is bypassed and reads come from flash.
// [RULE11] Invalidation flushes; software polls ready to see completion.
// [RULE12] External flush input flushes storage and tags at once.
// [RULE13] Identity: instance ID 15:10, part 9:6, release 5:0, read-only.
// [RULE14] Geometry: memory in 128KB units high, cache KB low, reading 16.
// [RULE15] All fields return to defaults on any reset.
// [RULE16] Miss while on fetches via fill buffer, returns word, allocates a way.
//
// Added by the designer: the plain strobed port.
`include "ucc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module ucc_top #(
  parameter int unsigned CACHE_KB  = 16,       // Storage size in KB
  parameter bit          SECONDARY = 1'b1,     // Instance uses shared bank
  parameter logic [5:0]  INST_ID   = 6'h01,    // Arbitrary value
  parameter logic [3:0]  PART_NUM  = 4'h1,     // Arbitrary value
  parameter logic [5:0]  REL_NUM   = 6'h01,    // Arbitrary value
  parameter logic [15:0] MEM_UNITS = 16'h0004  // Addressable memory, 128KB units
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // External flush and zeroize strobes
  input  wire logic        flush_in,
  input  wire logic        zeroize_in,
  // Processor fetch port
  input  wire logic        fetch_req_in,
  input  wire logic [31:0] fetch_addr_in,
  output logic             fetch_ack_out,
  output logic      [31:0] fetch_data_out,
  output logic             fetch_busy_out,
  // Flash port
  output logic             flash_req_out,
  output logic      [31:0] flash_addr_out,
  input  wire logic        flash_ack_in,
  input  wire logic [31:0] flash_data_in,
  // Shared bank access gate
  input  wire logic        bank_req_in,
  input  wire logic [31:0] bank_addr_in,
  input  wire logic        bank_risc_in,
  input  wire logic        risc_excl_in,
  output logic             bank_grant_out
);

  localparam int unsigned SETS  = CACHE_KB * `UCC_KB_BYTES / 8;
  localparam int unsigned SET_W = $clog2(SETS);
  localparam int unsigned TAG_W = 30 - SET_W;
  localparam logic [SET_W-1:0] LAST_SET = SET_W'(SETS - 1);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  ////////////////////////////////////////////////////////////////////////
  // Storage

  logic             vld  [2][SETS];
  logic [TAG_W-1:0] tags [2][SETS];
  logic [31:0]      mem  [2][SETS];
  logic             lru  [SETS];   // Next victim way

  ucc_pkg::ucc_state_t state;
  ucc_pkg::ucc_line_t  lbuf;
  logic                en;
  logic                walking;
  logic                zero_pend;
  logic [SET_W-1:0]    walk_idx;

  // Tag compare for one way
  function automatic logic tag_match(input logic v, input logic [TAG_W-1:0] a,
                                     input logic [TAG_W-1:0] b);
    tag_match = v && (a == b);
  endfunction : tag_match

  // Shared bank range check
  function automatic logic in_bank(input logic [31:0] a);
    in_bank = (a >= `UCC_BANK_LO) && (a <= `UCC_BANK_HI);
  endfunction : in_bank

  ////////////////////////////////////////////////////////////////////////
  // Decode

  // Register strobes
  wire sel_ident = reg_addr_in == `UCC_OFS_IDENTITY;
  wire sel_geom  = reg_addr_in == `UCC_OFS_GEOMETRY;
  wire sel_ctrl  = reg_addr_in == `UCC_OFS_CONTROL;
  wire sel_inval = reg_addr_in == `UCC_OFS_INVALIDATE;
  wire wr_ctrl   = reg_wr_in && sel_ctrl;
  wire wr_inval  = reg_wr_in && sel_inval;
  wire wr_off    = wr_ctrl && !reg_wdata_in[`UCC_EN_BIT];

  // Ready flag and walk start
  wire rdy        = !walking;                                        // RULE9
  wire start_walk = wr_inval || wr_off || flush_in || zeroize_in;    // RULE8

  // Lookup of the requested word
  wire [SET_W-1:0] req_set = fetch_addr_in[SET_W+1:2];
  wire [TAG_W-1:0] req_tag = fetch_addr_in[31:SET_W+2];
  wire cache_on  = en && rdy;                                        // RULE10
  wire hit0      = cache_on && tag_match(vld[0][req_set], tags[0][req_set], req_tag);
  wire hit1      = cache_on && tag_match(vld[1][req_set], tags[1][req_set], req_tag);
  wire lb_hit    = rdy && lbuf.valid && (lbuf.waddr == fetch_addr_in[31:2]); // RULE7
  wire any_hit   = hit0 || hit1 || lb_hit;
  wire [31:0] hit_data = hit0 ? mem[0][req_set] : hit1 ? mem[1][req_set] : lbuf.data;

  // Victim choice for the pending miss
  wire [SET_W-1:0] miss_set = flash_addr_out[SET_W+1:2];
  wire [TAG_W-1:0] miss_tag = flash_addr_out[31:SET_W+2];
  wire victim = !vld[0][miss_set] ? 1'b0 : !vld[1][miss_set] ? 1'b1 : lru[miss_set];
  wire fill_done = (state == ucc_pkg::UCC_MISS) && flash_ack_in;
  wire alloc     = fill_done && en && !walking && !start_walk;      // RULE16

  // Register read mux
  wire [31:0] ident_word = {16'h0000, INST_ID, PART_NUM, REL_NUM};  // RULE13
  wire [31:0] geom_word  = {MEM_UNITS, 16'(CACHE_KB)};              // RULE14
  wire [31:0] ctrl_word  = (32'(rdy) << `UCC_RDY_BIT) | (32'(en) << `UCC_EN_BIT);
  wire [31:0] rd_mux = sel_ident ? ident_word :
                       sel_geom  ? geom_word  :
                       sel_ctrl  ? ctrl_word  : `UCC_ZERO32;

  // Shared bank gate
  wire bank_open  = !(SECONDARY && en) && (bank_risc_in || !risc_excl_in);  // RULE3
  wire next_grant = bank_req_in && (!in_bank(bank_addr_in) || bank_open);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Enable bit and read data
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      en            <= `UCC_EN_RST;                                  // RULE15
      reg_rdata_out <= `UCC_ZERO32;
    end else begin
      if (wr_ctrl) begin
        en <= reg_wdata_in[`UCC_EN_BIT];                             // RULE6
      end
      reg_rdata_out <= reg_rd_in ? rd_mux : `UCC_ZERO32;
    end
  end

  // Invalidate walk, one set per cycle; reset starts one as well
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      walking   <= 1'b1;
      zero_pend <= 1'b1;
      walk_idx  <= '0;
    end else if (start_walk) begin
      walking   <= 1'b1;                                             // RULE12
      zero_pend <= zeroize_in;
      walk_idx  <= '0;
    end else if (walking) begin
      walk_idx <= walk_idx + 1'b1;
      walking  <= walk_idx != LAST_SET;                              // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage update: walk clears, miss allocates, hit ages

  always_ff @(posedge clk_in) begin
    if (walking) begin
      vld[0][walk_idx] <= 1'b0;
      vld[1][walk_idx] <= 1'b0;
      lru[walk_idx]    <= 1'b0;
      if (zero_pend) begin
        tags[0][walk_idx] <= '0;
        tags[1][walk_idx] <= '0;
        mem[0][walk_idx]  <= '0;
        mem[1][walk_idx]  <= '0;
      end
    end else if (alloc) begin
      vld[victim][miss_set]  <= 1'b1;                                // RULE1
      tags[victim][miss_set] <= miss_tag;
      mem[victim][miss_set]  <= flash_data_in;
      lru[miss_set]          <= !victim;
    end else if (state == ucc_pkg::UCC_IDLE && fetch_req_in && (hit0 || hit1)) begin
      lru[req_set] <= hit0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fetch sequencer

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state          <= ucc_pkg::UCC_IDLE;
      fetch_ack_out  <= 1'b0;
      fetch_data_out <= `UCC_ZERO32;
      fetch_busy_out <= 1'b0;
      flash_req_out  <= 1'b0;
      flash_addr_out <= `UCC_ZERO32;
      lbuf           <= '0;
    end else begin
      fetch_ack_out <= 1'b0;
      flash_req_out <= 1'b0;
      unique case (state)
        ucc_pkg::UCC_IDLE: begin
          if (fetch_req_in && any_hit) begin
            fetch_ack_out  <= 1'b1;
            fetch_data_out <= hit_data;
          end else if (fetch_req_in) begin
            flash_req_out  <= 1'b1;                                  // RULE10
            flash_addr_out <= {fetch_addr_in[31:2], 2'b00};
            fetch_busy_out <= 1'b1;
            state          <= ucc_pkg::UCC_MISS;
          end
        end
        ucc_pkg::UCC_MISS: begin
          if (flash_ack_in) begin
            fetch_ack_out  <= 1'b1;                                  // RULE16
            fetch_data_out <= flash_data_in;
            fetch_busy_out <= 1'b0;
            lbuf           <= {1'b1, flash_addr_out[31:2], flash_data_in};
            state          <= ucc_pkg::UCC_IDLE;
          end
        end
      endcase
      if (start_walk) begin
        lbuf.valid <= 1'b0;
      end
    end
  end

  // Shared bank grant
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bank_grant_out <= 1'b0;
    end else begin
      bank_grant_out <= next_grant;                                  // RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  chk_reset_walk: assert property ($past(rst_in) |-> !en && walking && !fetch_ack_out) // RULE15
    else $error("reset did not leave cache disabled and invalidating");

  chk_enable_on: assert property (wr_ctrl && reg_wdata_in[`UCC_EN_BIT] && !start_walk |=> en) // RULE6
    else $error("enable write did not set enable");

  chk_disable_inval: assert property (wr_off |=> !en && walking && !lbuf.valid) // RULE7
    else $error("disable did not invalidate");

  chk_inval_busy: assert property (wr_inval ##1 reg_rd_in && sel_ctrl |=> !reg_rdata_out[`UCC_RDY_BIT]) // RULE8
    else $error("ready read 1 right after invalidate");

  chk_rdy_done: assert property ($fell(walking) |-> rdy ##0 $past(walk_idx) == LAST_SET) // RULE9
    else $error("walk ended early or ready stuck low");

  chk_bypass_miss: assert property (state == ucc_pkg::UCC_IDLE && fetch_req_in && !rdy
                                    |=> flash_req_out && !fetch_ack_out) // RULE10
    else $error("fetch not sent to flash while not ready");

  chk_flush_now: assert property (flush_in |=> walking && walk_idx == '0) // RULE12
    else $error("flush did not start at once");

  chk_ident_read: assert property (reg_rd_in && sel_ident |=> reg_rdata_out[31:16] == 16'h0000
                                   && reg_rdata_out[15:`UCC_ID_LSB] == INST_ID) // RULE13
    else $error("identity read wrong");

  chk_geom_read: assert property (reg_rd_in && sel_geom |=> reg_rdata_out[15:0] == 16'(CACHE_KB)) // RULE14
    else $error("geometry read wrong");

  chk_bank_block: assert property (bank_req_in && in_bank(bank_addr_in) && en && SECONDARY
                                   |=> !bank_grant_out) // RULE2
    else $error("bank reachable while secondary cache on");

  chk_bank_open: assert property (bank_req_in && !en && !risc_excl_in |=> bank_grant_out) // RULE3
    else $error("bank not reopened after disable");

  chk_miss_return: assert property (fill_done |=> fetch_ack_out && !fetch_busy_out
                                    && fetch_data_out == $past(flash_data_in)) // RULE16
    else $error("miss did not return flash word");

  chk_hit_fast: assert property (state == ucc_pkg::UCC_IDLE && fetch_req_in && (hit0 || hit1)
                                 |=> fetch_ack_out && !flash_req_out) // RULE1
    else $error("hit did not answer next cycle");

  // Main scenarios
  cov_hit:      cover property (fetch_req_in && (hit0 || hit1));
  cov_alloc:    cover property (alloc ##1 fetch_ack_out);
  cov_lb_hit:   cover property (fetch_req_in && lb_hit && !en);
  cov_walk_end: cover property ($fell(walking));

endmodule : ucc_top

`default_nettype wire

// ### sim/ucc_flash_model.sv
// Flash memory model facing the cache controller's flash port.
// Assumes one request at a time, answered after a set delay.
`timescale 1ns/10ps
`default_nettype none

module ucc_flash_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Request side
  input  wire logic        req_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [3:0]  delay_in,
  // Answer side
  output logic             ack_out,
  output logic      [31:0] data_out
);
  logic        busy;
  logic [3:0]  cnt;
  logic [31:0] addr;
  logic [31:0] word;

  // Data lines show the inverse of the last word once the answer is gone
  assign data_out = ack_out ? word : ~word;

  // Counts down the delay, then answers with a word made from the address
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy    <= 1'b0;
      cnt     <= 4'h0;
      ack_out <= 1'b0;
      word    <= 32'h0000_0000;
    end else begin
      ack_out <= 1'b0;
      if (req_in) begin
        busy <= 1'b1;
        cnt  <= delay_in;
        addr <= addr_in;
      end else if (busy && cnt <= 4'h1) begin
        busy    <= 1'b0;
        ack_out <= 1'b1;
        word    <= {addr[31:2], 2'b00} ^ 32'hA5A5_5A5A;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : ucc_flash_model
`default_nettype wire

// ### sim/ucc_top_test.sv
// Self-checking bench of the cache controller: register, fetch, bank gate.
// Assumes ucc_consts.svh on the include path and the flash model.
`include "ucc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module ucc_top_test;
  logic clk, rst, wr, rd, flush, zero, freq, fack, busy, mreq, mack, breq, brisc, bexcl, bgrant;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, faddr, fdata, maddr, mdata, baddr, v;
  logic [3:0]  dly;
  int          n_fail, tests_run, n_flash;
  localparam logic [31:0] A = 32'h0000_1230, B = A + 32'h2000, C = A + 32'h4000;

  ucc_top #(.CACHE_KB(16), .INST_ID(6'h2A), .PART_NUM(4'h5),
    .REL_NUM(6'h13), .MEM_UNITS(16'h0008)) DUT (.clk_in(clk), .rst_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .flush_in(flush), .zeroize_in(zero), .fetch_req_in(freq), .fetch_addr_in(faddr),
    .fetch_ack_out(fack), .fetch_data_out(fdata), .fetch_busy_out(busy), .flash_req_out(mreq),
    .flash_addr_out(maddr), .flash_ack_in(mack), .flash_data_in(mdata), .bank_req_in(breq),
    .bank_addr_in(baddr), .bank_risc_in(brisc), .risc_excl_in(bexcl), .bank_grant_out(bgrant));
  ucc_flash_model FLASH (.clk_in(clk), .rst_in(rst), .req_in(mreq), .addr_in(maddr),
    .delay_in(dly), .ack_out(mack), .data_out(mdata));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, flash request count and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (mreq === 1'b1) n_flash++;
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus and port tasks
  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr32
  task automatic rd32(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd32
  // Polls ready with a bound well above one whole walk
  task automatic wait_rdy;
    for (int i = 0; i < 1500; i++) begin
      rd32(`UCC_OFS_CONTROL, v);
      if (v[`UCC_RDY_BIT] === 1'b1) break;
    end
    `CHK("ready", 1'b1, v[`UCC_RDY_BIT])
  endtask : wait_rdy
  task automatic fetch(input logic [31:0] a, input logic via_flash);
    int n0;
    n0 = n_flash;
    @(posedge clk);
    freq <= 1'b1; faddr <= a;
    @(posedge clk);
    freq <= 1'b0;
    for (int k = 0; k < 100; k++) begin
      @(negedge clk);
      if (fack === 1'b1) break;
    end
    `CHK("fetch data", {a[31:2], 2'b00} ^ 32'hA5A5_5A5A, fdata)
    `CHK("flash used", via_flash, logic'(n_flash != n0))
    `CHK("fetch busy", 1'b0, busy)
  endtask : fetch
  task automatic bank(input logic [31:0] a, input logic risc, input logic exp);
    @(posedge clk);
    breq <= 1'b1; baddr <= a; brisc <= risc;
    @(posedge clk);
    breq <= 1'b0;
    @(negedge clk);
    `CHK("bank grant", exp, bgrant)
  endtask : bank
  task automatic strobe(input bit fl);
    @(posedge clk);
    if (fl) flush <= 1'b1; else zero <= 1'b1;
    @(posedge clk);
    flush <= 1'b0; zero <= 1'b0;
  endtask : strobe
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, wr, rd, flush, zero, freq, breq, brisc, bexcl} = 9'h1FF;
    {wr, rd, flush, zero, freq, breq, brisc, bexcl} = 8'h00;
    addr = 12'h000; wdata = 32'h0; faddr = 32'h0; baddr = 32'h0; dly = 4'h1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd32(`UCC_OFS_CONTROL, v); `CHK("ctrl reset", 32'h0000_0000, v)
    rd32(`UCC_OFS_IDENTITY, v); `CHK("identity", {16'h0, 6'h2A, 4'h5, 6'h13}, v)
    wr32(`UCC_OFS_GEOMETRY, 32'hFFFF_FFFF);
    rd32(`UCC_OFS_GEOMETRY, v); `CHK("geometry", 32'h0008_0010, v)
    rd32(12'h008, v); `CHK("unmapped", 32'h0000_0000, v)
    rd32(`UCC_OFS_INVALIDATE, v); `CHK("inval read", 32'h0000_0000, v)
    wait_rdy();
    fetch(A, 1'b1); fetch(A, 1'b0);
    // Enable order, then zeroize
    wr32(`UCC_OFS_CONTROL, 32'h0); wr32(`UCC_OFS_CONTROL, 32'h1); wait_rdy();
    strobe(1'b0); wait_rdy();
    rd32(`UCC_OFS_CONTROL, v); `CHK("enabled", 32'h0001_0001, v)
    @(posedge clk) dly <= 4'h6;
    fetch(A, 1'b1); fetch(B, 1'b1); fetch(A, 1'b0); fetch(B, 1'b0);
    fetch(C, 1'b1); fetch(B, 1'b0); fetch(A, 1'b1);
    // Invalidate register, bypass during walk
    wr32(`UCC_OFS_INVALIDATE, 32'hDEAD_BEEF);
    rd32(`UCC_OFS_CONTROL, v); `CHK("walking", 32'h0000_0001, v)
    fetch(B, 1'b1); fetch(B, 1'b1);
    wait_rdy(); fetch(A, 1'b1); fetch(A, 1'b0);
    strobe(1'b1);
    rd32(`UCC_OFS_CONTROL, v); `CHK("flushing", 32'h0000_0001, v)
    wait_rdy(); fetch(A, 1'b1);
    bank(`UCC_BANK_LO, 1'b0, 1'b0); bank(`UCC_BANK_HI, 1'b1, 1'b0);
    bank(`UCC_BANK_LO - 32'h4, 1'b0, 1'b1);
    wr32(`UCC_OFS_CONTROL, 32'h0);
    rd32(`UCC_OFS_CONTROL, v); `CHK("disabled", 32'h0000_0000, v)
    wait_rdy(); fetch(B, 1'b1);
    bank(`UCC_BANK_LO, 1'b0, 1'b1);
    @(posedge clk) bexcl <= 1'b1;
    bank(`UCC_BANK_HI, 1'b0, 1'b0); bank(`UCC_BANK_HI, 1'b1, 1'b1);
    wr32(`UCC_OFS_CONTROL, 32'h1); wait_rdy();
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rd32(`UCC_OFS_CONTROL, v); `CHK("ctrl reset 2", 32'h0000_0000, v)
    close_out();
  end
endmodule : ucc_top_test
`default_nettype wire
